// ### serial_eeprom_command_port.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_port #(
   parameter int unsigned PULSE_CYCLES = eeprom_cmd_pkg::PROGRAM_PULSE_CYCLES
) (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic chip_select,
   input  wire logic serial_clock,
   input  wire logic serial_input,
   input  wire logic org_wide,
   output logic      serial_output,
   output logic      serial_output_oe_n,
   output logic      program_enabled,
   output logic      program_busy
);
   import eeprom_cmd_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HEADER,
      ST_DATA,
      ST_READ,
      ST_ARMED,
      ST_STATUS,
      ST_DONE
   } state_t;

   // ==========================================================
   // pin capture
   pins_t raw_pins;
   pins_t pins;
   assign raw_pins = '{select: chip_select, sclk: serial_clock, din: serial_input};

   pin_sync u_sync (
      .clock  (clock),
      .srst   (srst),
      .raw    (raw_pins),
      .synced (pins)
   );

   logic sclk_prev_q;
   logic sel_prev_q;
   logic wide_meta_q;
   logic wide_q;
   always_ff @(posedge clock) begin
      if (srst) begin
         sclk_prev_q <= 1'b0;
         sel_prev_q  <= 1'b0;
      end else begin
         sclk_prev_q <= pins.sclk;
         sel_prev_q  <= pins.select;
      end
   end

   // organisation strap is a pin like the others: two stages before use
   // limitation: changing it mid-frame garbles that frame
   always_ff @(posedge clock) begin
      if (srst) begin
         wide_meta_q <= 1'b1;
         wide_q      <= 1'b1;
      end else begin
         wide_meta_q <= org_wide;
         wide_q      <= wide_meta_q;
      end
   end

   logic rise;
   logic fall;
   logic sel_fall;
   assign rise     = pins.select && pins.sclk && !sclk_prev_q;
   assign fall     = pins.select && !pins.sclk && sclk_prev_q;
   assign sel_fall = sel_prev_q && !pins.select;
   // sync delay: pin edges are seen two clocks late, so each
   // serial clock phase must last at least four system clocks

   // ==========================================================
   // storage and timed programming
   logic [7:0]  mem_q [BYTE_COUNT];
   logic        timer_start;
   logic        timer_done;
   logic        timer_busy;
   prog_req_t   req_q;

   program_timer #(.CYCLES(PULSE_CYCLES)) u_timer (
      .clock (clock),
      .srst  (srst),
      .start (timer_start),
      .busy  (timer_busy),
      .done  (timer_done)
   );

   state_t      state_q;
   logic [4:0]  bit_cnt_q;
   logic [12:0] shift_q;
   logic [15:0] data_q;
   logic [10:0] addr_q;
   logic [15:0] rd_word_q;
   logic        lead_q;
   logic        unlocked_q;

   // ==========================================================
   // frame decode
   logic [4:0]  hdr_len;
   logic [4:0]  word_len;
   logic [10:0] frame_addr;
   logic [1:0]  frame_op;
   logic [12:0] shift_next;
   logic [10:0] top_addr;
   assign hdr_len    = wide_q ? 5'(WIDE_FRAME_BITS - 1) : 5'(NARROW_FRAME_BITS - 1);
   assign word_len   = wide_q ? 5'(WIDE_BITS) : 5'(NARROW_BITS);
   assign shift_next = {shift_q[11:0], pins.din};
   assign top_addr   = wide_q ? 11'(BYTE_COUNT / 2 - 1) : 11'(BYTE_COUNT - 1);
   // top address bit is received, then ignored
   assign frame_op   = wide_q ? shift_next[11:10] : shift_next[12:11];
   assign frame_addr = wide_q ? {2'b00, shift_next[8:0]} : {1'b0, shift_next[9:0]};

   logic [1:0] sub_code;
   assign sub_code = wide_q ? shift_next[9:8] : shift_next[10:9];

   // shift_q still holds the header while data bits arrive
   logic data_is_fill;
   assign data_is_fill = (wide_q ? shift_q[11:10] : shift_q[12:11]) == OP_EXTENDED;

   logic [10:0] next_addr;
   assign next_addr = (addr_q == top_addr) ? 11'h0 : addr_q + 11'h1;

   function automatic logic [15:0] fetch(input logic [10:0] a, input logic w);
      logic [9:0] b;
      b = w ? {a[8:0], 1'b0} : a[9:0];
      // x8 words leave the upper byte zero
      fetch = w ? {mem_q[b], mem_q[b + 10'h1]} : {8'h00, mem_q[b]};
   endfunction

   assign timer_start = (state_q == ST_ARMED) && sel_fall && (req_q.job != JOB_NONE);

   // ==========================================================
   // frame state machine
   always_ff @(posedge clock) begin
      if (srst) begin
         state_q   <= ST_IDLE;
         bit_cnt_q <= 5'h0;
         shift_q   <= 13'h0;
         data_q    <= 16'h0;
         addr_q    <= 11'h0;
         rd_word_q <= 16'h0;
         lead_q    <= 1'b0;
         req_q     <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               bit_cnt_q <= 5'h0;
               shift_q   <= 13'h0;
               // while busy a raised select only shows status; no frame is taken
               if (timer_busy && pins.select) begin
                  state_q <= ST_STATUS;
               end else if (rise && pins.din) begin
                  state_q   <= ST_HEADER;
                  bit_cnt_q <= 5'h1;
                  shift_q   <= 13'h1;
               end
            end
            ST_HEADER: begin
               if (!pins.select) begin
                  state_q <= ST_IDLE;
               end else if (rise) begin
                  shift_q   <= shift_next;
                  bit_cnt_q <= bit_cnt_q + 5'h1;
                  if (bit_cnt_q == hdr_len) begin
                     addr_q    <= frame_addr;
                     bit_cnt_q <= 5'h0;
                     req_q     <= '0;
                     if (frame_op == OP_READ) begin
                        state_q   <= ST_READ;
                        rd_word_q <= fetch(frame_addr, wide_q);
                        lead_q    <= 1'b1;
                     end else if (frame_op == OP_WRITE ||
                                  (frame_op == OP_EXTENDED && sub_code == SUB_FILL)) begin
                        state_q <= ST_DATA;
                     end else if (frame_op == OP_ERASE && unlocked_q) begin
                        state_q <= ST_ARMED;
                        req_q   <= '{job: JOB_ERASE, addr: frame_addr, data: {2{ERASED_BYTE}}, wide: wide_q};
                     end else if (frame_op == OP_EXTENDED && sub_code == SUB_CLEAR && unlocked_q) begin
                        state_q <= ST_ARMED;
                        req_q   <= '{job: JOB_CLEAR, addr: 11'h0, data: {2{ERASED_BYTE}}, wide: wide_q};
                     end else begin
                        state_q <= ST_DONE;
                     end
                  end
               end
            end
            ST_DATA: begin
               if (!pins.select) begin
                  state_q <= ST_IDLE;
               end else if (rise) begin
                  data_q    <= {data_q[14:0], pins.din};
                  bit_cnt_q <= bit_cnt_q + 5'h1;
                  if (bit_cnt_q == word_len - 5'h1) begin
                     // locked: data is swallowed, no job armed
                     state_q <= unlocked_q ? ST_ARMED : ST_DONE;
                     req_q   <= '{job: (!unlocked_q) ? JOB_NONE : (data_is_fill ? JOB_FILL : JOB_WRITE),
                                  addr: addr_q, data: {data_q[14:0], pins.din}, wide: wide_q};
                  end
               end
            end
            ST_ARMED: begin
               // only a select drop before the next rising edge commits
               if (sel_fall) begin
                  state_q <= ST_IDLE;
               end else if (rise) begin
                  state_q <= ST_DONE;
                  req_q   <= '0;
               end
            end
            ST_READ: begin
               if (!pins.select) begin
                  state_q <= ST_IDLE;
               end else if (rise) begin
                  // word was fetched at the end of the header, during the lead zero
                  if (lead_q) begin
                     lead_q    <= 1'b0;
                     bit_cnt_q <= 5'h0;
                  end else if (bit_cnt_q == word_len - 5'h1) begin
                     addr_q    <= next_addr;
                     rd_word_q <= fetch(next_addr, wide_q);
                     bit_cnt_q <= 5'h0;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 5'h1;
                  end
               end
            end
            ST_STATUS: begin
               // release honoured only once ready, so a poller cannot miss ready
               if (!pins.select) begin
                  state_q <= ST_IDLE;
               end else if (fall && pins.din && !timer_busy) begin
                  state_q <= ST_DONE;
               end
            end
            default: begin
               if (!pins.select && !timer_busy) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // program lock
   // only a full header changes the latch; a cut frame leaves it
   always_ff @(posedge clock) begin
      if (srst) begin
         unlocked_q <= 1'b0;
      end else if (state_q == ST_HEADER && rise && bit_cnt_q == hdr_len && frame_op == OP_EXTENDED) begin
         if (sub_code == SUB_UNLOCK) begin
            unlocked_q <= 1'b1;
         end else if (sub_code == SUB_LOCK) begin
            unlocked_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // array update at the end of the timed pulse
   logic [9:0] wr_base;
   assign wr_base = req_q.wide ? {req_q.addr[8:0], 1'b0} : req_q.addr[9:0];

   // the whole word is replaced, so no prior erase is needed
   for (genvar i = 0; i < BYTE_COUNT; i++) begin : g_mem
      always_ff @(posedge clock) begin
         if (srst) begin
            mem_q[i] <= ERASED_BYTE;
         // done lasts one cycle, so every job lands exactly once
         end else if (timer_done) begin
            if (req_q.job == JOB_CLEAR) begin
               mem_q[i] <= ERASED_BYTE;
            end else if (req_q.job == JOB_FILL) begin
               mem_q[i] <= (req_q.wide && (i % 2 == 0)) ? req_q.data[15:8] : req_q.data[7:0];
            end else if (req_q.job == JOB_WRITE || req_q.job == JOB_ERASE) begin
               if (10'(i) == wr_base) begin
                  mem_q[i] <= req_q.wide ? req_q.data[15:8] : req_q.data[7:0];
               end else if (req_q.wide && 10'(i) == wr_base + 10'h1) begin
                  mem_q[i] <= req_q.data[7:0];
               end
            end
         end
      end
   end

   // ==========================================================
   // output pin
   logic [4:0] bit_idx;
   assign bit_idx = word_len - 5'h1 - bit_cnt_q;

   logic drive_read;
   logic drive_status;
   assign drive_read   = (state_q == ST_READ) && pins.select;
   assign drive_status = (state_q == ST_STATUS) && pins.select;

   always_ff @(posedge clock) begin
      if (srst) begin
         serial_output      <= 1'b0;
         serial_output_oe_n <= 1'b1;
         program_enabled    <= 1'b0;
         program_busy       <= 1'b0;
      end else begin
         program_enabled <= unlocked_q;
         program_busy    <= timer_busy;
         if (drive_read) begin
            serial_output_oe_n <= 1'b0;
            serial_output      <= lead_q ? 1'b0 : rd_word_q[bit_idx[3:0]];
         end else if (drive_status) begin
            serial_output_oe_n <= 1'b0;
            serial_output      <= !timer_busy;
         end else begin
            serial_output_oe_n <= 1'b1;
            serial_output      <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### eeprom_cmd_pkg.sv
package eeprom_cmd_pkg;

   // ==========================================================
   // geometry
   localparam int unsigned ARRAY_BITS      = 8192;
   localparam int unsigned WIDE_BITS       = 16;
   localparam int unsigned NARROW_BITS     = 8;
   localparam int unsigned WIDE_ADDR_BITS  = 10;
   localparam int unsigned NARROW_ADDR_BITS = 11;
   localparam int unsigned WIDE_FRAME_BITS = 13;
   localparam int unsigned NARROW_FRAME_BITS = 14;
   localparam int unsigned BYTE_COUNT      = ARRAY_BITS / NARROW_BITS;
   localparam logic [7:0]  ERASED_BYTE     = 8'hff;

   // ==========================================================
   // opcodes and subcodes
   localparam logic [1:0] OP_EXTENDED = 2'h0;
   localparam logic [1:0] OP_WRITE    = 2'h1;
   localparam logic [1:0] OP_READ     = 2'h2;
   localparam logic [1:0] OP_ERASE    = 2'h3;
   localparam logic [1:0] SUB_LOCK    = 2'h0;
   localparam logic [1:0] SUB_FILL    = 2'h1;
   localparam logic [1:0] SUB_CLEAR   = 2'h2;
   localparam logic [1:0] SUB_UNLOCK  = 2'h3;

   // ==========================================================
   // timing
   localparam int unsigned CLOCK_MHZ          = 100;
   localparam int unsigned PROGRAM_PULSE_US   = 5000;
   localparam int unsigned PROGRAM_PULSE_CYCLES = PROGRAM_PULSE_US * CLOCK_MHZ;

   typedef enum logic [2:0] {
      JOB_NONE,
      JOB_WRITE,
      JOB_ERASE,
      JOB_FILL,
      JOB_CLEAR
   } job_t;

   // pending self-timed job, latched at the end of a frame
   typedef struct packed {
      job_t        job;
      logic [10:0] addr;
      logic [15:0] data;
      logic        wide;
   } prog_req_t;

   // serial pins after synchronisation
   typedef struct packed {
      logic select;
      logic sclk;
      logic din;
   } pins_t;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input  wire logic                    clock,
   input  wire logic                    srst,
   input  wire eeprom_cmd_pkg::pins_t   raw,
   output var  eeprom_cmd_pkg::pins_t   synced
);
   import eeprom_cmd_pkg::*;

   pins_t meta_q;

   // two stages; only the second stage is visible to logic
   always_ff @(posedge clock) begin
      if (srst) begin
         meta_q <= '0;
         synced <= '0;
      end else begin
         meta_q <= raw;
         synced <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### program_timer.sv
`timescale 1ns/1ps
`default_nettype none
module program_timer #(
   parameter int unsigned CYCLES = eeprom_cmd_pkg::PROGRAM_PULSE_CYCLES
) (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   import eeprom_cmd_pkg::*;

   logic [31:0] count_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         count_q <= 32'h0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy    <= 1'b1;
            count_q <= 32'(CYCLES - 1);
         end else if (busy) begin
            if (count_q == 32'h0) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count_q <= count_q - 32'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### eeprom_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_port_monitor #(
   parameter int unsigned PULSE_CYCLES = 50
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic chip_select,
   input wire logic serial_clock,
   input wire logic serial_input,
   input wire logic org_wide,
   input wire logic serial_output,
   input wire logic serial_output_oe_n,
   input wire logic program_enabled,
   input wire logic program_busy
);
   logic [31:0] busy_cnt_q;
   logic        sclk_q;
   logic [7:0]  rise_cnt_q;

   // ==========================================
   // serial clock rises since select went high
   always_ff @(posedge clock) begin
      if (srst || !chip_select) begin
         sclk_q     <= 1'h0;
         rise_cnt_q <= 8'h0;
      end else begin
         sclk_q <= serial_clock;
         if (serial_clock && !sclk_q) begin
            rise_cnt_q <= rise_cnt_q + 8'h1;
         end
      end
   end

   // ==========================================
   // busy length counter
   always_ff @(posedge clock) begin
      if (srst || !program_busy) begin
         busy_cnt_q <= 32'h0;
      end else begin
         busy_cnt_q <= busy_cnt_q + 32'h1;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_reset_quiet: assert property (disable iff (1'h0) srst |=>
      serial_output_oe_n && !program_enabled && !program_busy)
      else $error("outputs not quiet after reset");
   a_deselect_hiz: assert property ((!chip_select)[*6] |-> serial_output_oe_n)
      else $error("output driven while deselected");
   a_oe_needs_select: assert property ($fell(serial_output_oe_n) |-> chip_select)
      else $error("output enabled without select");
   a_status_low: assert property (program_busy && !serial_output_oe_n |-> !serial_output)
      else $error("status high while busy");
   a_status_ready: assert property ($fell(program_busy) && chip_select |-> ##[0:3] serial_output)
      else $error("status not high after busy");
   a_busy_unlocked: assert property ($rose(program_busy) |-> program_enabled)
      else $error("timed cycle while locked");
   a_busy_deselect: assert property ($rose(program_busy) |-> !chip_select)
      else $error("timed cycle started while selected");
   a_busy_length: assert property ($fell(program_busy) |-> busy_cnt_q == PULSE_CYCLES)
      else $error("timed cycle length wrong");
   a_enable_steady: assert property ($changed(program_enabled) |-> !program_busy)
      else $error("enable latch moved during timed cycle");
   a_frame_length: assert property ($fell(serial_output_oe_n) && !program_busy |->
      rise_cnt_q == (org_wide ? 8'(eeprom_cmd_pkg::WIDE_FRAME_BITS) :
                                8'(eeprom_cmd_pkg::NARROW_FRAME_BITS)))
      else $error("read output began after wrong frame length");
   a_lead_zero: assert property ($fell(serial_output_oe_n) |-> !serial_output)
      else $error("first driven bit not zero");
   a_read_on_rise: assert property ($changed(serial_output) && !serial_output_oe_n &&
      !$past(serial_output_oe_n) && !$past(program_busy) |-> $past(serial_clock, 4) && !$past(serial_clock, 5))
      else $error("read bit changed away from a rising edge");
   a_dummy_release: assert property ($rose(serial_output_oe_n) && chip_select |->
      !$past(serial_clock, 4) && $past(serial_clock, 5) && $past(serial_input, 4))
      else $error("output released without dummy one on falling edge");
endmodule
`default_nettype wire

// ### eeprom_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_model (
   input  wire logic clock,
   output var  logic chip_select,
   output var  logic serial_clock,
   output var  logic serial_input,
   input  wire logic serial_output
);
   // min_deselect_time at the slower supply: 250 ns
   localparam int DESELECT_CYCLES = 25;

   initial begin
      chip_select  = 1'h0;
      serial_clock = 1'h0;
      serial_input = 1'h0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask

   // data set a half period ahead of each rise; sample just before the rise
   task automatic shift(input logic [31:0] v, input int n, output logic [31:0] got);
      got = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         chip_select  <= 1'h1;
         serial_input <= v[i];
         step(5);
         got = {got[30:0], serial_output};
         serial_clock <= 1'h1;
         step(5);
         serial_clock <= 1'h0;
      end
   endtask

   // drop select before the next rise, data line no longer held
   task automatic deselect();
      chip_select  <= 1'h0;
      serial_input <= ~serial_input;
      step(DESELECT_CYCLES);
   endtask
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import eeprom_cmd_pkg::*;
   logic        clock;
   logic        srst;
   logic        org_wide;
   wire logic   chip_select;
   wire logic   serial_clock;
   wire logic   serial_input;
   logic        serial_output;
   logic        serial_output_oe_n;
   logic        program_enabled;
   logic        program_busy;
   // a released output line floats to its pull-up
   wire logic   out_line = serial_output_oe_n ? 1'h1 : serial_output;
   int          bad_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   logic [31:0] g;

   always #5 clock = ~clock;

   serial_eeprom_command_port #(.PULSE_CYCLES(50)) dut (.clock(clock), .srst(srst),
      .chip_select(chip_select), .serial_clock(serial_clock), .serial_input(serial_input),
      .org_wide(org_wide), .serial_output(serial_output), .serial_output_oe_n(serial_output_oe_n),
      .program_enabled(program_enabled), .program_busy(program_busy));
   eeprom_host_model host (.clock(clock), .chip_select(chip_select), .serial_clock(serial_clock),
      .serial_input(serial_input), .serial_output(out_line));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ==========================================
   // shared frame helpers
   task automatic rd(input logic [9:0] a, input logic [15:0] exp);
      host.shift({19'h0, 1'h1, OP_READ, a}, 13, g);
      host.shift(32'h0, 17, g);
      chk("lead zero", 32'h0, {31'h0, g[16]});
      chk("read word", {16'h0, exp}, {16'h0, g[15:0]});
   endtask

   task automatic nxt(input logic [15:0] exp);
      host.shift(32'h0, 16, g);
      chk("next word", {16'h0, exp}, {16'h0, g[15:0]});
   endtask

   task automatic cmd(input logic [1:0] op, input logic [9:0] a, input logic [15:0] d, input bit wd);
      if (wd) host.shift({3'h0, 1'h1, op, a, d}, 29, g);
      else host.shift({19'h0, 1'h1, op, a}, 13, g);
      host.deselect();
   endtask

   task automatic poll();
      int n;
      n = 0;
      chk("busy", 32'h1, {31'h0, program_busy});
      host.chip_select <= 1'h1;
      host.step(8);
      chk("status oe", 32'h0, {31'h0, serial_output_oe_n});
      chk("status busy", 32'h0, {31'h0, serial_output});
      while (program_busy === 1'h1 && n < 100) begin
         host.step(1);
         n++;
      end
      chk("busy ended", 32'h0, {31'h0, program_busy});
      host.step(6);
      chk("status ready", 32'h1, {31'h0, serial_output});
      host.shift(32'h1, 1, g);
      host.step(6);
      chk("dummy release", 32'h1, {31'h0, serial_output_oe_n});
      host.deselect();
   endtask

   // ==========================================
   // scenarios
   task automatic t_reset();
      chk("oe reset", 32'h1, {31'h0, serial_output_oe_n});
      chk("lock reset", 32'h0, {31'h0, program_enabled});
      host.shift({29'h0, 1'h1, OP_READ}, 3, g);
      host.deselect();
      rd(10'h0, 16'hffff);
      host.deselect();
      $display("test reset done");
   endtask

   task automatic t_locked();
      cmd(OP_WRITE, 10'h5, 16'h1234, 1'h1);
      chk("locked write", 32'h0, {31'h0, program_busy});
      cmd(OP_EXTENDED, {SUB_FILL, 8'h0}, 16'h0, 1'h1);
      chk("locked fill", 32'h0, {31'h0, program_busy});
      rd(10'h5, 16'hffff);
      host.deselect();
      $display("test locked done");
   endtask

   task automatic t_write();
      cmd(OP_EXTENDED, {SUB_UNLOCK, 8'h0}, 16'h0, 1'h0);
      chk("unlock", 32'h1, {31'h0, program_enabled});
      cmd(OP_WRITE, 10'h5, 16'ha5c3, 1'h1);
      poll();
      cmd(OP_WRITE, 10'h0, 16'h3c3c, 1'h1);
      poll();
      cmd(OP_WRITE, 10'h5, 16'h5a0f, 1'h1);
      poll();
      rd(10'h4, 16'hffff);
      nxt(16'h5a0f);
      host.deselect();
      rd(10'h1ff, 16'hffff);
      nxt(16'h3c3c);
      host.deselect();
      $display("test write done");
   endtask

   task automatic t_erase_narrow();
      cmd(OP_ERASE, 10'h5, 16'h0, 1'h0);
      poll();
      rd(10'h5, 16'hffff);
      host.deselect();
      org_wide <= 1'h0;
      host.step(2);
      host.shift({18'h0, 1'h1, OP_READ, 11'h1}, 14, g);
      host.shift(32'h0, 9, g);
      chk("narrow byte", 32'h03c, {23'h0, g[8:0]});
      host.deselect();
      org_wide <= 1'h1;
      host.step(2);
      $display("test erase and narrow done");
   endtask

   task automatic t_bulk_lock();
      cmd(OP_EXTENDED, {SUB_FILL, 8'h0}, 16'h0ff0, 1'h1);
      poll();
      rd(10'h12c, 16'h0ff0);
      host.deselect();
      cmd(OP_EXTENDED, {SUB_CLEAR, 8'h0}, 16'h0, 1'h0);
      poll();
      rd(10'h12c, 16'hffff);
      host.deselect();
      cmd(OP_WRITE, 10'h0, 16'h3c3c, 1'h1);
      poll();
      host.shift({3'h0, 1'h1, OP_WRITE, 10'h0, 16'h1111}, 29, g);
      host.shift(32'h0, 1, g);
      host.deselect();
      chk("late drop", 32'h0, {31'h0, program_busy});
      cmd(OP_EXTENDED, {SUB_LOCK, 8'h0}, 16'h0, 1'h0);
      chk("lock", 32'h0, {31'h0, program_enabled});
      cmd(OP_ERASE, 10'h0, 16'h0, 1'h0);
      chk("locked erase", 32'h0, {31'h0, program_busy});
      rd(10'h0, 16'h3c3c);
      host.deselect();
      $display("test bulk and lock done");
   endtask

   initial begin
      clock    = 1'h0;
      srst     = 1'h1;
      org_wide = 1'h1;
      repeat (5) @(posedge clock);
      srst <= 1'h0;
      host.step(20);
      t_reset();
      t_locked();
      t_write();
      t_erase_narrow();
      t_bulk_lock();
      tally_and_finish();
   end
endmodule

bind serial_eeprom_command_port eeprom_port_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) mon (
   .clock(clock), .srst(srst), .chip_select(chip_select), .serial_clock(serial_clock),
   .serial_input(serial_input), .org_wide(org_wide), .serial_output(serial_output),
   .serial_output_oe_n(serial_output_oe_n), .program_enabled(program_enabled),
   .program_busy(program_busy));
`default_nettype wire
